//--- rtl/isrd_top.v
`timescale 1ns/1ps
`include "isrd_map.vh"

// What this block does
// - claim only when A9..A5 match switches
// - switch on OFF side reads as one
// - window spans 32 bytes at base
// - factory straps: 0x220, dma 6/7, irq 10
// - dma only on channels 5, 6, 7
// - request and acknowledge on same channel
// - two dma paths, dual mode by software
// - works with dma 2 or both disabled
// - drive one of eleven irq lines
// - irq line driven through tristate
// - irq only with exactly one selection
module isrd_top (
  input  wire        sys_clk_i,
  input  wire        rstn_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [9:0]  host_addr_i,
  input  wire        host_aen_i,
  input  wire        host_ior_n_i,
  input  wire        host_iow_n_i,
  input  wire [2:0]  host_dack_n_i,
  output reg  [2:0]  host_drq_o,
  output reg  [10:0] host_irq_o,
  output reg  [10:0] host_irq_oe_n_o,
  input  wire [4:0]  base_sw_off_i,
  input  wire [2:0]  dma1_rq_jmp_i,
  input  wire [2:0]  dma1_ack_jmp_i,
  input  wire [2:0]  dma2_rq_jmp_i,
  input  wire [2:0]  dma2_ack_jmp_i,
  input  wire [10:0] irq_jmp_i,
  input  wire        acq_dreq_i,
  input  wire        acq_irq_req_i,
  output reg         acq_dack_o,
  output reg         acq_dack_path_o,
  output reg         io_claim_o,
  output reg         io_rd_o,
  output reg  [4:0]  io_offset_o
);

  // exactly-one test, shared by dma and irq strap checks
  function onehot;
    input [10:0] v;
    integer      i;
    reg   [3:0]  n;
    begin
      n = 4'h0;
      for (i = 0; i < 11; i = i + 1)
        n = n + {3'h0, v[i]};
      onehot = (n == 4'h1);
    end
  endfunction

  wire [43:0] raw_in;
  wire [43:0] raw_rst;
  wire [43:0] syn;

  // field order here fixes the syn slices taken below
  assign raw_in = {
    host_addr_i,
    host_aen_i,
    host_ior_n_i,
    host_iow_n_i,
    host_dack_n_i,
    base_sw_off_i,
    dma1_rq_jmp_i,
    dma1_ack_jmp_i,
    dma2_rq_jmp_i,
    dma2_ack_jmp_i,
    irq_jmp_i
  };
  // reset values keep the decoder quiet: aen and strobes high, no dma
  // acknowledge, straps at the factory setup
  assign raw_rst = {
    10'h000,
    1'b1,
    1'b1,
    1'b1,
    3'h7,
    `ISRD_DEF_BASE,
    `ISRD_DEF_DMA1,
    `ISRD_DEF_DMA1,
    `ISRD_DEF_DMA2,
    `ISRD_DEF_DMA2,
    `ISRD_DEF_IRQ
  };

  // every host pin and strap passes two flops before use; acq and wishbone inputs do not
  isrd_sync #(
    .W (`ISRD_SYNC_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (raw_in),
    .rst_val_i (raw_rst),
    .sync_o    (syn)
  );

  wire [9:0]  s_addr;
  wire        s_aen;
  wire        s_ior_n;
  wire        s_iow_n;
  wire [2:0]  s_dack_n;
  wire [4:0]  s_base;
  wire [2:0]  s_d1r;
  wire [2:0]  s_d1a;
  wire [2:0]  s_d2r;
  wire [2:0]  s_d2a;
  wire [10:0] s_irq;

  assign s_addr   = syn[43:34];
  assign s_aen    = syn[33];
  assign s_ior_n  = syn[32];
  assign s_iow_n  = syn[31];
  assign s_dack_n = syn[30:28];
  assign s_base   = syn[27:23];
  assign s_d1r    = syn[22:20];
  assign s_d1a    = syn[19:17];
  assign s_d2r    = syn[16:14];
  assign s_d2a    = syn[13:11];
  assign s_irq    = syn[10:0];

  // strap copies; reset holds the factory setup until the pins are seen
  // a strap change needs three edges to reach the decoders
  reg [4:0]  base_cfg;
  reg [2:0]  d1r_cfg;
  reg [2:0]  d1a_cfg;
  reg [2:0]  d2r_cfg;
  reg [2:0]  d2a_cfg;
  reg [10:0] irq_cfg;

  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      base_cfg <= `ISRD_DEF_BASE;
      d1r_cfg  <= `ISRD_DEF_DMA1;
      d1a_cfg  <= `ISRD_DEF_DMA1;
      d2r_cfg  <= `ISRD_DEF_DMA2;
      d2a_cfg  <= `ISRD_DEF_DMA2;
      irq_cfg  <= `ISRD_DEF_IRQ;
    end
    else
    begin
      // OFF side of a switch is already a one on its pin
      base_cfg <= s_base;
      d1r_cfg  <= s_d1r;
      d1a_cfg  <= s_d1a;
      d2r_cfg  <= s_d2r;
      d2a_cfg  <= s_d2a;
      irq_cfg  <= s_irq;
    end
  end

  // control register
  reg [2:0] ctrl;
  wire      dma_en;
  wire      dual_en;
  wire      irq_en;

  assign dma_en  = ctrl[`ISRD_CTRL_DMA_EN];
  assign dual_en = ctrl[`ISRD_CTRL_DUAL_EN];
  assign irq_en  = ctrl[`ISRD_CTRL_IRQ_EN];

  // a path is usable only with one channel among 5..7 and the same
  // channel on both jumper columns; anything else disables it
  wire d1_ok;
  wire d2_ok;

  assign d1_ok = onehot({8'h00, d1r_cfg}) && (d1r_cfg == d1a_cfg);
  assign d2_ok = onehot({8'h00, d2r_cfg}) && (d2r_cfg == d2a_cfg);

  // dual mode alternates paths on each finished acknowledge
  // one toggle is all the state that two paths need
  reg  alt_path;
  reg  ack_seen;
  wire cur_path;
  wire cur_ok;
  wire [2:0] cur_ch;
  wire ack_now;

  assign cur_path = (dual_en && d1_ok && d2_ok) ? alt_path :
                    (d1_ok ? 1'b0 : 1'b1);
  assign cur_ok   = cur_path ? d2_ok : d1_ok;
  assign cur_ch   = cur_path ? d2r_cfg : d1r_cfg;
  // acknowledge is watched only on the channel that carries the request
  assign ack_now  = cur_ok && |(~s_dack_n & cur_ch);

  wire [2:0] next_drq;

  assign next_drq = (dma_en && cur_ok && acq_dreq_i) ? cur_ch :
                    3'h0;

  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      host_drq_o      <= 3'h0;
      acq_dack_o      <= 1'b0;
      acq_dack_path_o <= 1'b0;
      alt_path        <= 1'b0;
      ack_seen        <= 1'b0;
    end
    else
    begin
      host_drq_o      <= next_drq;
      acq_dack_o      <= ack_now && dma_en;
      acq_dack_path_o <= cur_path;
      ack_seen        <= ack_now;
      // switch paths only once the cycle on the old one has ended
      if (ack_seen && !ack_now && dual_en && d1_ok && d2_ok)
        alt_path <= ~alt_path;
      else if (!(d1_ok && d2_ok))
        alt_path <= 1'b0;
    end
  end

  // io window decode
  wire base_hit;
  wire strobe;

  assign base_hit =
    (s_addr[`ISRD_BASE_MSB:`ISRD_BASE_LSB] == base_cfg);
  // dma cycles drive aen high, so they never claim the window
  assign strobe   = !s_aen && (!s_ior_n || !s_iow_n);

  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      io_claim_o  <= 1'b0;
      io_rd_o     <= 1'b0;
      io_offset_o <= 5'h00;
    end
    else
    begin
      io_claim_o  <= base_hit && strobe;
      io_rd_o     <= base_hit && !s_aen && !s_ior_n;
      // offset follows the pins every cycle; qualify it with the claim
      io_offset_o <= s_addr[`ISRD_OFF_MSB:0];
    end
  end

  // interrupt line: enabled only when a single jumper is fitted
  wire irq_ok;

  assign irq_ok = onehot(irq_cfg);

  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      host_irq_o      <= 11'h000;
      host_irq_oe_n_o <= 11'h7ff;
    end
    else
    begin
      // level goes to every jumpered bit; only the enable picks the line
      host_irq_o <= irq_cfg & {11{acq_irq_req_i}};
      // enable low drives the line; all others float for sharing
      if (irq_ok && irq_en)
        host_irq_oe_n_o <= ~irq_cfg;
      else
        host_irq_oe_n_o <= 11'h7ff;
    end
  end

  // configuration warnings the host should not cause; reported only
  wire base_low;
  wire irq_bad;

  assign base_low = (base_cfg[4:3] == 2'h0);
  assign irq_bad  = |(irq_cfg & `ISRD_IRQ_BAD_MASK);

  // the only writable offset; status and unused offsets drop writes
  function ctrl_sel;
    input [7:0] adr;
    begin
      ctrl_sel = (adr == `ISRD_CTRL_OFF);
    end
  endfunction

  // wishbone classic slave, ack one cycle after the request
  wire        wb_req;
  reg  [31:0] next_rd;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always @*
  begin
    next_rd = 32'h0000_0000;
    case (wb_adr_i)
      `ISRD_CTRL_OFF:
        next_rd[2:0] = ctrl;
      `ISRD_STAT_OFF:
      begin
        next_rd[`ISRD_ST_BASE_HI:`ISRD_ST_BASE_LO]     = base_cfg;
        next_rd[`ISRD_ST_DMA1_OK]                      = d1_ok;
        next_rd[`ISRD_ST_DMA2_OK]                      = d2_ok;
        next_rd[`ISRD_ST_DMA1_CH_HI:`ISRD_ST_DMA1_CH_LO] = d1r_cfg;
        next_rd[`ISRD_ST_DMA2_CH_HI:`ISRD_ST_DMA2_CH_LO] = d2r_cfg;
        next_rd[`ISRD_ST_IRQ_OK]                       = irq_ok;
        next_rd[`ISRD_ST_IRQ_HI:`ISRD_ST_IRQ_LO]       = irq_cfg;
        next_rd[`ISRD_ST_BASE_LOW]                     = base_low;
        next_rd[`ISRD_ST_IRQ_BAD]                      = irq_bad;
        next_rd[`ISRD_ST_PATH]                         = cur_path;
      end
      default:
        next_rd = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      ctrl     <= `ISRD_CTRL_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      // zero outside an ack keeps an or-combined read bus clean
      wb_dat_o <= wb_req ? next_rd : 32'h0000_0000;
      if (wb_req && wb_we_i && wb_sel_i[0] &&
          ctrl_sel(wb_adr_i))
        ctrl <= wb_dat_i[2:0];
    end
  end

endmodule // isrd_top

//--- shared/isrd_map.vh
`ifndef ISRD_MAP_VH
`define ISRD_MAP_VH

// wishbone register byte offsets
`define ISRD_CTRL_OFF        8'h00
`define ISRD_STAT_OFF        8'h04

// control register fields and reset value
`define ISRD_CTRL_DMA_EN     0
`define ISRD_CTRL_DUAL_EN    1
`define ISRD_CTRL_IRQ_EN     2
`define ISRD_CTRL_RST        3'h7

// status register field positions
`define ISRD_ST_BASE_LO      0
`define ISRD_ST_BASE_HI      4
`define ISRD_ST_DMA1_OK      5
`define ISRD_ST_DMA2_OK      6
`define ISRD_ST_DMA1_CH_LO   7
`define ISRD_ST_DMA1_CH_HI   9
`define ISRD_ST_DMA2_CH_LO   10
`define ISRD_ST_DMA2_CH_HI   12
`define ISRD_ST_IRQ_OK       13
`define ISRD_ST_IRQ_LO       14
`define ISRD_ST_IRQ_HI       24
`define ISRD_ST_BASE_LOW     25
`define ISRD_ST_IRQ_BAD      26
`define ISRD_ST_PATH         27

// factory strap values: base 0x220, dma 6 and 7, irq level 10
`define ISRD_DEF_BASE        5'h11
`define ISRD_DEF_DMA1        3'h2
`define ISRD_DEF_DMA2        3'h4
`define ISRD_DEF_IRQ         11'h040

// irq lines 6 and 14 belong to the disk controllers
`define ISRD_IRQ_BAD_MASK    11'h208

// address split: compared bits and in-window offset
`define ISRD_BASE_MSB        9
`define ISRD_BASE_LSB        5
`define ISRD_OFF_MSB         4

`define ISRD_SYNC_W          44

`endif

//--- rtl/isrd_sync.v
`timescale 1ns/1ps

module isrd_sync #(
  parameter W = 1
) (
  input  wire         sys_clk_i,
  input  wire         rstn_i,
  input  wire [W-1:0] async_i,
  input  wire [W-1:0] rst_val_i,
  output wire [W-1:0] sync_o
);

  genvar g;

  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      reg meta;
      reg stable;
      // reset value matters at every reset, until two edges after it; synchronous reset so a
      // port value is legal here
      always @(posedge sys_clk_i)
      begin
        if (!rstn_i)
        begin
          meta   <= rst_val_i[g];
          stable <= rst_val_i[g];
        end
        else
        begin
          meta   <= async_i[g];
          stable <= meta;
        end
      end
      assign sync_o[g] = stable;
    end
  endgenerate

endmodule // isrd_sync

//--- sim/isrd_host_model.sv
`timescale 1ns/1ps
module isrd_host_model (
  input  wire [2:0] host_drq_i,
  input  wire       sys_clk_i,
  output reg  [2:0] host_dack_n_o = 3'h7
);
  reg [2:0] cnt = 3'h0;
  // slow grant: ack arrives late and drops so the device may switch path
  always @(posedge sys_clk_i)
  begin
    cnt <= cnt + 3'h1;
    if (cnt == 3'h3)
      host_dack_n_o <= ~host_drq_i;
    if (cnt == 3'h6)
      host_dack_n_o <= 3'h7;
  end
endmodule // isrd_host_model

//--- sim/isrd_top_sva.sv
`timescale 1ns/1ps
module isrd_top_sva (
  input wire        sys_clk_i,
  input wire        rstn_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [9:0]  host_addr_i,
  input wire [4:0]  base_sw_off_i,
  input wire        io_claim_o,
  input wire [4:0]  io_offset_o,
  input wire        acq_dreq_i,
  input wire [2:0]  host_drq_o,
  input wire [2:0]  dma1_rq_jmp_i,
  input wire [2:0]  dma1_ack_jmp_i,
  input wire [2:0]  dma2_rq_jmp_i,
  input wire [2:0]  dma2_ack_jmp_i,
  input wire        acq_irq_req_i,
  input wire [10:0] host_irq_o,
  input wire [10:0] host_irq_oe_n_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic [9:0] p1, p2, p3;
  // two sync stages plus the claim register
  always_ff @(posedge sys_clk_i)
  begin
    p1 <= host_addr_i;
    p2 <= p1;
    p3 <= p2;
  end
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_claim_base: assert property (
    io_claim_o |-> p3[9:5] == base_sw_off_i) else $error("bad claim");
  a_claim_offset: assert property (
    io_claim_o |-> io_offset_o == p3[4:0]) else $error("bad offset");
  a_drq_cause: assert property (
    host_drq_o != 3'h0 |-> $past(acq_dreq_i)) else $error("stray drq");
  a_drq_path: assert property (host_drq_o != 3'h0 |->
    (host_drq_o == dma1_rq_jmp_i && dma1_rq_jmp_i == dma1_ack_jmp_i) ||
    (host_drq_o == dma2_rq_jmp_i && dma2_rq_jmp_i == dma2_ack_jmp_i))
    else $error("drq off path");
  a_irq_single: assert property (
    host_irq_oe_n_o != 11'h7ff |-> $onehot(~host_irq_oe_n_o))
    else $error("irq lines");
  a_irq_level: assert property (host_irq_oe_n_o != 11'h7ff |->
    (|(host_irq_o & ~host_irq_oe_n_o)) == $past(acq_irq_req_i))
    else $error("irq level");
endmodule // isrd_top_sva
bind isrd_top isrd_top_sva u_sva (.sys_clk_i, .rstn_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .host_addr_i, .base_sw_off_i, .io_claim_o,
  .io_offset_o, .acq_dreq_i, .host_drq_o, .dma1_rq_jmp_i,
  .dma1_ack_jmp_i, .dma2_rq_jmp_i, .dma2_ack_jmp_i, .acq_irq_req_i,
  .host_irq_o, .host_irq_oe_n_o);

//--- sim/isrd_top_tb.sv
`timescale 1ns/1ps
module isrd_top_tb;
  logic        clk, rstn, cyc, stb, we, ack, aen, ior_n, iow_n;
  logic        dreq, irq_rq, claim, rd, e, dack, dpath;
  logic [1:0]  k;
  logic [3:0]  sel, wsel;
  logic [7:0]  adr;
  logic [31:0] wdat, dat, rdat;
  logic [9:0]  addr, a;
  logic [4:0]  sw, offs;
  logic [11:0] dj;
  logic [2:0]  dack_n, drq, m1, m2;
  logic [10:0] jmp, irq, oe_n;
  int          fail_count, checks, ci;
  isrd_top u_dut (
    .sys_clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat), .wb_ack_o(ack), .host_addr_i(addr),
    .host_aen_i(aen), .host_ior_n_i(ior_n), .host_iow_n_i(iow_n),
    .host_dack_n_i(dack_n), .host_drq_o(drq), .host_irq_o(irq),
    .host_irq_oe_n_o(oe_n), .base_sw_off_i(sw),
    .dma1_rq_jmp_i(dj[11:9]), .dma1_ack_jmp_i(dj[8:6]),
    .dma2_rq_jmp_i(dj[5:3]), .dma2_ack_jmp_i(dj[2:0]),
    .irq_jmp_i(jmp), .acq_dreq_i(dreq), .acq_irq_req_i(irq_rq),
    .acq_dack_o(dack), .acq_dack_path_o(dpath), .io_claim_o(claim),
    .io_rd_o(rd), .io_offset_o(offs));
  isrd_host_model u_host (.sys_clk_i(clk), .host_drq_i(drq),
    .host_dack_n_o(dack_n));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    $display("fail_count=%0d checks=%0d", fail_count, checks);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, ad, d, wsel};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rdat = dat;
    {cyc, stb} <= 2'h0;
    @(posedge clk);
  endtask
  // straps only move under reset, as jumpers would on a powered-down card
  task automatic rst(input logic [4:0] s, input logic [11:0] d,
                     input logic [10:0] j);
    {rstn, dreq, irq_rq, aen, ior_n, iow_n} <= 6'h3;
    {sw, dj, jmp} <= {s, d, j};
    tick(12);
    rstn <= 1'b1;
    tick(6);
  endtask
  function automatic logic [31:0] st(input logic [4:0] s,
    input logic [11:0] d, input logic [10:0] j);
    st = {5'h0, |(j & 11'h208), s < 5'h8, j, $onehot(j), d[5:3],
      d[11:9], d[5:3] == d[2:0] && $onehot(d[5:3]),
      d[11:9] == d[8:6] && $onehot(d[11:9]), s};
  endfunction
  // paths a run shows: both when dual mode alternates, else dma1 if usable
  function automatic logic [1:0] pm(input logic [2:0] c, input logic o1,
                                    input logic o2);
    pm = (c[0] && c[1] && o1 && o2) ? 2'h3 : (o1 ? 2'h1 : 2'h2);
  endfunction
  task automatic dma_case(input logic [11:0] d, input logic [2:0] c,
                          input logic [2:0] x);
    logic [2:0] seen;
    logic [1:0] ph;
    logic       dk;
    logic       ok1;
    logic       ok2;
    seen = 3'h0;
    ph = 2'h0;
    dk = 1'b0;
    ok1 = d[11:9] == d[8:6] && $onehot(d[11:9]);
    ok2 = d[5:3] == d[2:0] && $onehot(d[5:3]);
    rst(5'h11, d, 11'h040);
    wb(1'b1, 8'h00, {29'h0, c});
    dreq <= 1'b1;
    repeat (60)
    begin
      @(posedge clk);
      seen = seen | drq;
      dk = dk | dack;
      ph = ph | (2'h1 << dpath);
    end
    cmp({29'h0, seen}, {29'h0, x});
    cmp({31'h0, dk}, {31'h0, x != 3'h0});
    cmp({30'h0, ph}, {30'h0, pm(c, ok1, ok2)});
  endtask
  task automatic irq_case(input logic [10:0] j, input logic [2:0] c,
                          input logic [10:0] x);
    rst(5'h11, 12'h4a4, j);
    wb(1'b1, 8'h00, {29'h0, c});
    irq_rq <= 1'b1;
    tick(3);
    cmp({21'h0, oe_n}, {21'h0, ~x});
    cmp({21'h0, irq & ~oe_n}, {21'h0, x});
    wb(1'b0, 8'h04, 32'h0);
    cmp(rdat, st(5'h11, 12'h4a4, j));
    irq_rq <= 1'b0;
    tick(2);
    cmp({21'h0, irq}, 32'h0);
  endtask
  initial
  begin
    {cyc, stb, we, aen, dreq, irq_rq, rstn} = 7'h0;
    {ior_n, iow_n, adr, wdat, addr} = {2'h3, 50'h0};
    {sel, wsel} = {4'h0, 4'h1};
    {sw, dj, jmp} = {5'h11, 12'h4a4, 11'h040};
    {fail_count, checks} = {32'h0, 32'h0};
    ci = $urandom(32'hf53ea41b);
    rst(5'h11, 12'h4a4, 11'h040);
    wb(1'b0, 8'h00, 32'h0);
    cmp(rdat, 32'h7);
    wb(1'b1, 8'h04, 32'hffffffff);
    wb(1'b0, 8'h04, 32'h0);
    cmp(rdat, st(5'h11, 12'h4a4, 11'h040));
    wb(1'b0, 8'h10, 32'h0);
    cmp(rdat, 32'h0);
    // a control write without byte lane 0 must leave control alone
    wsel = 4'he;
    wb(1'b1, 8'h00, 32'h0);
    wsel = 4'h1;
    wb(1'b0, 8'h00, 32'h0);
    cmp(rdat, 32'h7);
    for (int i = 0; i < 30; i++)
    begin
      if (i % 10 == 0)
        rst(5'(8 + $urandom_range(23)), 12'h4a4, 11'h040);
      case (i % 5)
        0: a = {sw, 5'h00};
        1: a = {sw, 5'h1f};
        2: a = {sw, 5'h00} - 10'h1;
        3: a = {sw, 5'h1f} + 10'h1;
        default: a = 10'($urandom);
      endcase
      k = 2'($urandom);
      {addr, iow_n, ior_n} <= {a, k};
      aen <= ($urandom_range(5) == 0);
      tick(4);
      e = !aen && k != 2'h3 && a[9:5] == sw;
      cmp({25'h0, claim, rd, claim ? offs : 5'h0},
          {25'h0, e, e && !k[0], e ? a[4:0] : 5'h0});
    end
    dma_case(12'h4a4, 3'h7, 3'h6);
    dma_case(12'h4a4, 3'h5, 3'h2);
    dma_case(12'h240, 3'h7, 3'h1);
    dma_case(12'h000, 3'h7, 3'h0);
    dma_case(12'h2a4, 3'h7, 3'h4);
    dma_case(12'h4a4, 3'h6, 3'h0);
    ci = $urandom_range(2);
    m1 = 3'h1 << ci;
    m2 = 3'h1 << ((ci + 1) % 3);
    dma_case({m1, m1, m2, m2}, 3'h7, m1 | m2);
    for (int i = 0; i < 11; i++)
      irq_case(11'h1 << i, 3'h7, 11'h1 << i);
    irq_case(11'h000, 3'h7, 11'h0);
    irq_case(11'h041, 3'h7, 11'h0);
    irq_case(11'h040, 3'h3, 11'h0);
    end_sim;
  end
  initial
  begin
    #200000;
    fail_count++;
    end_sim;
  end
endmodule // isrd_top_tb
